// *** hw/lst_serializer_tx.sv ***
// Multi-channel serializer with forwarded clock, built from logic cells.
// Assumes clk_in is the fast serial clock from the PLL and that the core
// presents par_data_in in the clk_in domain, held until word_take_out pulses.
`timescale 1ns/1ps
`default_nettype none

module lst_serializer_tx
  import lst_pkg::*;
#(
  parameter int NUM_CHANNELS  = DEF_NUM_CHANNELS,
  parameter int SER_FACTOR    = DEF_SER_FACTOR,
  parameter int CLK_DIV_RATIO = DEF_CLK_DIV_RATIO
) (
  input  wire logic                               clk_in,
  input  wire logic                               resetn_in,
  input  wire logic                               data_clear_in,
  input  wire logic                               pll_locked_in,
  input  wire logic [NUM_CHANNELS*SER_FACTOR-1:0] par_data_in,
  output logic      [NUM_CHANNELS-1:0]            ser_out,
  output logic                                    fwd_clk_out,
  output logic                                    word_take_out,
  output logic                                    tx_active_out
);

  localparam int WCW     = $clog2(SER_FACTOR);
  localparam int DCW     = $clog2(CLK_DIV_RATIO);
  localparam int FWD_HI  = lst_fwd_high(CLK_DIV_RATIO);
  localparam logic [WCW-1:0] LAST_BIT = WCW'(SER_FACTOR - 1);
  localparam logic [DCW-1:0] LAST_DIV = DCW'(CLK_DIV_RATIO - 1);
  localparam logic [DCW-1:0] HI_CNT   = DCW'(FWD_HI);

  if (SER_FACTOR < MIN_SER_FACTOR || NUM_CHANNELS < 1 || CLK_DIV_RATIO < MIN_DIV_RATIO) begin : g_bad
    $error("lst_serializer_tx: unsupported parameter values");
  end

  // Clear acts like reset but leaves the PLL alone; release is not synchronised,
  // the lock synchroniser restarts the link cleanly afterwards
  logic rst_n;
  assign rst_n = resetn_in & ~data_clear_in;

  logic       lock_s1_q;
  logic       lock_s2_q;
  lst_state_t state_q;
  logic [WCW-1:0] bit_q;
  logic [DCW-1:0] div_q;
  logic [DCW-1:0] div_d;
  logic           run_q;
  logic           load;
  logic           shift_en;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= pll_locked_in;
      lock_s2_q <= lock_s1_q;
    end
  end

  assign run_q = (state_q == ST_RUN);
  assign load  = lock_s2_q && (!run_q || bit_q == LAST_BIT);
  // Lock loss must silence the lanes at once, not one bit later
  assign shift_en = run_q && lock_s2_q;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (lock_s2_q) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!lock_s2_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_q         <= '0;
      word_take_out <= 1'b0;
      tx_active_out <= 1'b0;
    end else begin
      bit_q         <= load ? '0 : (run_q ? bit_q + 1'b1 : '0);
      word_take_out <= load;
      tx_active_out <= lock_s2_q;
    end
  end

  // Per-channel data path, MSB of each channel group leaves first
  if (SER_FACTOR == DDR_SER_FACTOR) begin : g_ddr
    logic [NUM_CHANNELS-1:0] lo_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        ser_out <= '0;
        lo_q    <= '0;
      end else begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          if (load) begin
            ser_out[c] <= par_data_in[c*SER_FACTOR+1];
            lo_q[c]    <= par_data_in[c*SER_FACTOR];
          end else begin
            ser_out[c] <= shift_en ? lo_q[c] : 1'b0;
          end
        end
      end
    end
  end else begin : g_shift
    logic [SER_FACTOR-1:0] sh_q [NUM_CHANNELS];
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        ser_out <= '0;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          sh_q[c] <= '0;
        end
      end else begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          if (load) begin
            ser_out[c] <= par_data_in[c*SER_FACTOR+SER_FACTOR-1];
            sh_q[c]    <= par_data_in[c*SER_FACTOR +: SER_FACTOR] << 1;
          end else if (shift_en) begin
            ser_out[c] <= sh_q[c][SER_FACTOR-1];
            sh_q[c]    <= sh_q[c] << 1;
          end else begin
            ser_out[c] <= 1'b0;
          end
        end
      end
    end
  end

  // Forwarded clock; restarts with the first word, so it stays word aligned while SER_FACTOR is a multiple of CLK_DIV_RATIO
  always_comb begin
    if (!run_q || div_q == LAST_DIV) begin
      div_d = '0;
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_q       <= '0;
      fwd_clk_out <= 1'b0;
    end else if (!lock_s2_q) begin
      div_q       <= '0;
      fwd_clk_out <= 1'b0;
    end else begin
      div_q       <= div_d;
      fwd_clk_out <= (div_d < HI_CNT);
    end
  end

  // Helper counters for checks
  logic [WCW:0] since_q;
  logic         first_q;
  logic [DCW:0] hi_len_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      since_q  <= '0;
      first_q  <= 1'b1;
      hi_len_q <= '0;
    end else begin
      since_q  <= word_take_out ? '0 : since_q + 1'b1;
      first_q  <= word_take_out ? 1'b0 : (first_q || !run_q);
      hi_len_q <= fwd_clk_out ? hi_len_q + 1'b1 : '0;
    end
  end

  AST_IDLE_QUIET: assert property (@(posedge clk_in) disable iff (!rst_n)
    !run_q |-> (ser_out == '0 && !fwd_clk_out))
    else $error("Transmitter active before lock");

  AST_START_ON_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n)
    (!run_q && lock_s2_q) |=> (run_q && word_take_out && fwd_clk_out))
    else $error("Serializing did not start on edge after lock");

  AST_STOP_ON_UNLOCK: assert property (@(posedge clk_in) disable iff (!rst_n)
    (run_q && !lock_s2_q) |=> ((!run_q && ser_out == '0 && !fwd_clk_out) ##1 !word_take_out))
    else $error("Transmitter kept running after lock loss");

  AST_WORD_PERIOD: assert property (@(posedge clk_in) disable iff (!rst_n)
    (word_take_out && !first_q) |-> (since_q == (WCW+1)'(SER_FACTOR - 1)))
    else $error("Word period differs from factor");

  AST_MSB_FIRST: assert property (@(posedge clk_in) disable iff (!rst_n)
    word_take_out |-> ser_out[0] == $past(par_data_in[SER_FACTOR-1]))
    else $error("First serial bit is not the group MSB");

  AST_SECOND_BIT: assert property (@(posedge clk_in) disable iff (!rst_n)
    (word_take_out && lock_s2_q) |=> ser_out[NUM_CHANNELS-1] ==
      $past(par_data_in[NUM_CHANNELS*SER_FACTOR-2], 2))
    else $error("Second serial bit out of order");

  AST_FWD_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n)
    (run_q && $fell(fwd_clk_out) && $past(lock_s2_q)) |-> hi_len_q == (DCW+1)'(FWD_HI))
    else $error("Forwarded clock high time wrong");

  AST_CLEAR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    data_clear_in |-> (!run_q && ser_out == '0 && !word_take_out && !lock_s2_q))
    else $error("Clear did not reset transmitter");

  COV_START: cover property (@(posedge clk_in) disable iff (!rst_n)
    !run_q ##1 run_q);
  COV_TWO_WORDS: cover property (@(posedge clk_in) disable iff (!rst_n)
    word_take_out && !first_q);
  COV_UNLOCK: cover property (@(posedge clk_in) disable iff (!rst_n)
    run_q ##1 !run_q);
  COV_CLEAR: cover property (@(posedge clk_in) disable iff (!resetn_in)
    data_clear_in ##1 !data_clear_in);

endmodule

`default_nettype wire

// *** hw/lst_pkg.sv ***
// Constants and types shared by the multi-channel serializing transmitter.
// Assumes a single fast serial clock; the parallel word rate is derived from it.
package lst_pkg;

  localparam int DEF_NUM_CHANNELS  = 44;
  localparam int DEF_SER_FACTOR    = 10;
  localparam int DEF_CLK_DIV_RATIO = 10;
  localparam int MIN_SER_FACTOR    = 2;
  localparam int MIN_DIV_RATIO     = 2;
  localparam int DDR_SER_FACTOR    = 2;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } lst_state_t;

  // High time of the forwarded clock in fast cycles; odd ratios cannot split evenly
  function automatic int lst_fwd_high(input int ratio);
    if ((ratio % 2) == 0) begin
      return ratio / 2;
    end
    return (ratio + 1) / 2;
  endfunction

endpackage

// *** tb/lst_rx_model.sv ***
// Receiver model: deserializes each lane, first bit in at the top.
// Assumes lanes are sampled on the rising fast clock edge.
`timescale 1ns/1ps
`default_nettype none
module lst_rx_model #(
  parameter int N = 1,
  parameter int F = 2
) (
  input  wire logic           clk_in,
  input  wire logic [N-1:0]   ser_in,
  output logic      [N*F-1:0] rx_word_out
);
  // Free-running shifter; the bench reads it at word boundaries
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < N; c++) begin
      rx_word_out[c*F +: F] <= {rx_word_out[c*F +: F-1], ser_in[c]};
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the serializer, with a receiver model.
// Assumes a 250 MHz fast clock and lock driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int N = 3;
  localparam int F = 5;
  localparam int R = 5;
  localparam int W = N*F;
  localparam int W2 = N*2;
  logic         clk_in;
  logic         resetn_in;
  logic         data_clear_in;
  logic         pll_locked_in;
  logic [W-1:0] par_data_in;
  logic [N-1:0] ser_out;
  logic         fwd_clk_out;
  logic         word_take_out;
  logic         tx_active_out;
  logic [W-1:0] rx_word;
  logic [W2-1:0] par2_in;
  logic [N-1:0]  ser2;
  logic          fwd2;
  logic          take2;
  logic          act2;
  logic [W2-1:0] cur2;
  logic [W2-1:0] exp2;
  int            cyc;
  logic [31:0]  seed;
  logic [W-1:0] cur;
  logic [W-1:0] exp_w;
  int           failures;
  int           n_checks;

  lst_serializer_tx #(.NUM_CHANNELS(N), .SER_FACTOR(F), .CLK_DIV_RATIO(R)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .data_clear_in(data_clear_in),
    .pll_locked_in(pll_locked_in), .par_data_in(par_data_in), .ser_out(ser_out),
    .fwd_clk_out(fwd_clk_out), .word_take_out(word_take_out),
    .tx_active_out(tx_active_out));
  lst_rx_model #(.N(N), .F(F)) i_rx (.clk_in(clk_in), .ser_in(ser_out), .rx_word_out(rx_word));
  // Factor two takes the double-rate path; it shares clock, reset, clear and lock
  lst_serializer_tx #(.NUM_CHANNELS(N), .SER_FACTOR(2), .CLK_DIV_RATIO(2)) i_dut_ddr (
    .clk_in(clk_in), .resetn_in(resetn_in), .data_clear_in(data_clear_in),
    .pll_locked_in(pll_locked_in), .par_data_in(par2_in), .ser_out(ser2),
    .fwd_clk_out(fwd2), .word_take_out(take2), .tx_active_out(act2));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [N-1:0] exp_ser(input logic [W-1:0] w, input int i);
    logic [N-1:0] r;
    for (int c = 0; c < N; c++) begin
      r[c] = w[c*F+F-1-i];
    end
    return r;
  endfunction

  function automatic logic [N-1:0] exp_ser2(input logic [W2-1:0] w, input int i);
    logic [N-1:0] r;
    for (int c = 0; c < N; c++) begin
      r[c] = w[c*2+1-i];
    end
    return r;
  endfunction

  task automatic summarize();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  task automatic idle(input string name);
    check(W'({ser_out, fwd_clk_out, word_take_out, tx_active_out, ser2, fwd2, take2, act2}), '0);
    $display("test %s done", name);
  endtask

  // Lock passes a two-flop synchroniser, so the first word loads three edges on
  task automatic wait_take();
    int k;
    k = 0;
    while (word_take_out !== 1'b1) begin
      if (k == 8) begin
        failures++;
        summarize();
      end
      tick();
      k++;
    end
    check(W'(k), W'(3));
    check(W'(tx_active_out), W'(1));
    check(W'(act2), W'(1));
    cyc = 0;
  endtask

  task automatic run_words(input int n);
    for (int w = 0; w < n; w++) begin
      for (int i = 0; i < F; i++) begin
        if (i == 0) begin
          if (w > 0) check(rx_word, exp_w);
          exp_w = cur;
          seed = lfsr(seed);
          cur = (w == 1) ? '1 : (w == 2) ? '0 : W'(seed);
          par_data_in = cur;
        end
        check(W'(word_take_out), W'(i == 0));
        check(W'(ser_out), W'(exp_ser(exp_w, i)));
        check(W'(fwd_clk_out), W'(i < (R + 1) / 2));
        if (cyc % 2 == 0) begin
          exp2 = cur2;
          seed = lfsr(seed);
          cur2 = W2'(seed >> 8);
          par2_in = cur2;
        end
        check(W'(take2), W'(cyc % 2 == 0));
        check(W'(ser2), W'(exp_ser2(exp2, cyc % 2)));
        check(W'(fwd2), W'(cyc % 2 == 0));
        cyc++;
        tick();
      end
    end
    $display("test words x%0d done", n);
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    seed = 32'h1144;
    resetn_in = 1'b0;
    data_clear_in = 1'b0;
    pll_locked_in = 1'b0;
    cur = W'(15'h4210);
    par_data_in = cur;
    cur2 = W2'(6'h2d);
    par2_in = cur2;
    cyc = 0;
    repeat (8) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    repeat (10) tick();
    idle("no lock");
    pll_locked_in = 1'b1;
    wait_take();
    run_words(8);
    pll_locked_in = 1'b0;
    repeat (3) tick();
    idle("lock loss");
    pll_locked_in = 1'b1;
    wait_take();
    run_words(6);
    tick();
    data_clear_in = 1'b1;
    #1;
    idle("clear");
    tick();
    data_clear_in = 1'b0;
    wait_take();
    run_words(4);
    resetn_in = 1'b0;
    #1;
    idle("reset");
    tick();
    resetn_in = 1'b1;
    wait_take();
    run_words(3);
    summarize();
  end
endmodule
`default_nettype wire
